/* design/gdfi_desat_chan.sv */
// one channel of desaturation protection with blanking and decaying threshold
`timescale 1ns/1ps
module gdfi_desat_chan #(
	parameter int SENSE_W = gdfi_pkg::SENSE_W
) (
	input  wire logic               clk,      // 10 MHz clock
	input  wire logic               arst_n,   // async reset, active low
	input  wire logic               gate_on,  // transistor commanded on
	input  wire logic [SENSE_W-1:0] sense,    // synchronised sense level
	output logic                    trip      // short circuit seen
);
	import gdfi_pkg::*;

	localparam int BW = $clog2(BLANK_CYCLES + 1);
	localparam logic [BW-1:0] BLANK_LAST = BW'(BLANK_CYCLES);

	logic [BW-1:0]      blank_cnt;
	logic [SENSE_W-1:0] thr;

	// ---------------------------------------------------------------
	// blanking counter, restarted at every turn-on
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			blank_cnt <= '0;
		else if (!gate_on)
			blank_cnt <= '0;
		else if (blank_cnt != BLANK_LAST)
			blank_cnt <= blank_cnt + BW'(1);
	end

	// ---------------------------------------------------------------
	// threshold starts high and decays to steady value
	// ---------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			thr <= SENSE_W'(THR_INIT);
		else if (!gate_on)
			thr <= SENSE_W'(THR_INIT);
		else if (thr > SENSE_W'(THR_STEADY) + SENSE_W'(THR_DECAY_STEP))
			thr <= thr - SENSE_W'(THR_DECAY_STEP);
		else
			thr <= SENSE_W'(THR_STEADY);
	end

	// compare only while on and after blanking
	assign trip = gate_on && (blank_cnt == BLANK_LAST) && (sense > thr);

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_trip_after_blank: assert property (@(posedge clk) disable iff (!arst_n)
		trip |-> $past(gate_on, 1) && blank_cnt == BLANK_LAST)
		else $error("desat trip inside blanking interval");
	a_thr_rearm_off: assert property (@(posedge clk) disable iff (!arst_n)
		!gate_on |=> thr == SENSE_W'(THR_INIT))
		else $error("threshold not returned to initial value");
	a_thr_never_rises: assert property (@(posedge clk) disable iff (!arst_n)
		gate_on && $past(gate_on) |-> thr <= $past(thr))
		else $error("threshold rose while transistor on");

endmodule

/* design/gdfi_pkg.sv */
// constants shared by the gate driver fault interlock block
package gdfi_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS     = 100;
	// clear hold must be strictly longer than the printed time
	localparam int CLEAR_HOLD_NS     = 9000;
	localparam int CLEAR_HOLD_CYCLES = CLEAR_HOLD_NS / CLK_PERIOD_NS + 1;
	// built-in interlock dead time, least time so rounded up
	localparam int DEAD_TIME_NS      = 2000;
	localparam int DEAD_CYCLES       = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// desat blanking interval, least time so rounded up
	localparam int BLANK_NS          = 3000;
	localparam int BLANK_CYCLES      = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// desat threshold shape and reset values
	// ---------------------------------------------------------------
	localparam int          SENSE_W           = 8;
	localparam logic [7:0]  THR_INIT          = 8'hc0;
	localparam logic [7:0]  THR_STEADY        = 8'h60;
	localparam logic [7:0]  THR_DECAY_STEP    = 8'h04;
	localparam logic        FAULT_RESET_VALUE = 1'b1;
	localparam int          CHAN_HIGH         = 0;
	localparam int          CHAN_LOW          = 1;

endpackage

/* design/gdfi_top.sv */
// fault latch, shutdown input, top/bottom interlock and desat protection
// Notes on behaviour
// - any fault sets the latch and raises the fault flag
// - while latched, commands are ignored and transistors stay off
// - latch clears only when fault gone and both commands low over 9 us
// - fault flag is open collector, low means no fault, released means fault
// - shutdown input high permits switching, low forces transistors off
// - shutdown low sets the latch, raises flag, commands ignored
// - shutdown fault clears after input high and commands low over 9 us
// - high and low transistors are never on together
// - dead time is the larger of built-in and controller dead time
// - one switching signal and its complement may drive both commands
// - desat is watched only while on; a short turns off and faults
// - desat watching starts after a blanking interval from turn-on
// - threshold starts high, decays, and resets at turn-off
// - after blanking, sense over threshold turns off and sets the latch
// - commands are active high: high on, low off
`timescale 1ns/1ps
module gdfi_top #(
	parameter int SENSE_W = gdfi_pkg::SENSE_W
) (
	input  wire logic               clk,                    // 10 MHz clock
	input  wire logic               arst_n,                 // async reset, active low
	input  wire logic               high_cmd,               // high-side switch command
	input  wire logic               low_cmd,                // low-side switch command
	input  wire logic               shutdown_in_n,          // shutdown, active low
	input  wire logic [SENSE_W-1:0] high_side_desat_sense,  // high-side sense level
	input  wire logic [SENSE_W-1:0] low_side_desat_sense,   // low-side sense level
	output logic                    high_gate_on,           // high-side transistor on
	output logic                    low_gate_on,            // low-side transistor on
	output logic                    fault_flag_out,         // fault flag drive level
	output logic                    fault_flag_oe           // fault flag pull-down enable
);
	import gdfi_pkg::*;

	localparam int CW = $clog2(CLEAR_HOLD_CYCLES + 1);
	localparam int DW = $clog2(DEAD_CYCLES + 1);
	// the clearing edge is itself the last quiet cycle, hence one short
	localparam logic [CW-1:0] CLEAR_LAST = CW'(CLEAR_HOLD_CYCLES - 1);
	localparam logic [DW-1:0] DEAD_DONE  = DW'(DEAD_CYCLES);

	// ---------------------------------------------------------------
	// input synchronisers
	// ---------------------------------------------------------------
	logic [1:0]         cmd_s1;
	logic [1:0]         cmd_s2;
	logic               sd_s1;
	logic               sd_s2;
	logic [SENSE_W-1:0] sense_s1 [2];
	logic [SENSE_W-1:0] sense_s2 [2];

	// two flops on every command, shutdown and sense pin before use
	// shutdown stage resets high so an idle pin never trips a false fault
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cmd_s1      <= 2'h0;
			cmd_s2      <= 2'h0;
			sd_s1       <= 1'b1;
			sd_s2       <= 1'b1;
			sense_s1[0] <= '0;
			sense_s1[1] <= '0;
			sense_s2[0] <= '0;
			sense_s2[1] <= '0;
		end
		else
		begin
			cmd_s1      <= {low_cmd, high_cmd};
			cmd_s2      <= cmd_s1;
			sd_s1       <= shutdown_in_n;
			sd_s2       <= sd_s1;
			sense_s1[0] <= high_side_desat_sense;
			sense_s1[1] <= low_side_desat_sense;
			sense_s2[0] <= sense_s1[0];
			sense_s2[1] <= sense_s1[1];
		end
	end

	// ---------------------------------------------------------------
	// fault latch and clear hold timer
	// ---------------------------------------------------------------
	logic [1:0]    gate;
	logic [1:0]    trip;
	logic          fault;
	logic          fault_cond;
	logic          quiet;
	logic [CW-1:0] clr_cnt;

	// shutdown low or any desat trip is a live fault
	assign fault_cond = !sd_s2 || (|trip);
	// qualifying cycle for clearing
	assign quiet = fault && !fault_cond && (cmd_s2 == 2'h0);

	// hold timer restarts whenever the quiet interval breaks
	// count stops at CLEAR_LAST, never wraps
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			clr_cnt <= '0;
		else if (!quiet)
			clr_cnt <= '0;
		else if (clr_cnt != CLEAR_LAST)
			clr_cnt <= clr_cnt + CW'(1);
	end

	// set wins over clear
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			fault <= FAULT_RESET_VALUE;
		else if (fault_cond)
			fault <= 1'b1;
		else if (quiet && clr_cnt == CLEAR_LAST)
			fault <= 1'b0;
	end

	// open collector: pull low for no fault, release for fault
	// fault_flag_out is the pull-down level, only meaningful while enabled
	assign fault_flag_out = 1'b0;
	assign fault_flag_oe  = !fault;

	// ---------------------------------------------------------------
	// per channel interlock, gate drive and desat
	// ---------------------------------------------------------------
	logic [DW-1:0] dcnt [2];

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_chan
			// cycles this gate has been off, saturating
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					dcnt[i] <= DEAD_DONE;
				else if (gate[i])
					dcnt[i] <= '0;
				else if (dcnt[i] != DEAD_DONE)
					dcnt[i] <= dcnt[i] + DW'(1);
			end

			// a live fault also blocks, so no turn-on slips in as the latch sets
			// turn on only once the other side has been off for the dead time
			always_ff @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
					gate[i] <= 1'b0;
				else if (fault || fault_cond || !cmd_s2[i] || trip[i])
					gate[i] <= 1'b0;
				else if (!gate[i] && !cmd_s2[1-i] && !gate[1-i] && dcnt[1-i] == DEAD_DONE)
					gate[i] <= 1'b1;
			end

			gdfi_desat_chan #(
				.SENSE_W (SENSE_W)
			) gdfi_desat_chan_i (
				.clk     (clk),
				.arst_n  (arst_n),
				.gate_on (gate[i]),
				.sense   (sense_s2[i]),
				.trip    (trip[i])
			);
		end
	endgenerate

	assign high_gate_on = gate[CHAN_HIGH];
	assign low_gate_on  = gate[CHAN_LOW];

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	a_gates_exclusive: assert property (!(gate[0] && gate[1]))
		else $error("both transistors on");
	a_fault_sets_flag: assert property (fault_cond |=> fault && !fault_flag_oe)
		else $error("fault did not raise flag");
	a_latch_blocks_on: assert property ($rose(gate[0]) || $rose(gate[1]) |-> !$past(fault))
		else $error("turn-on while fault latched");
	a_shutdown_forces: assert property (!sd_s2 |=> gate == 2'h0 && fault)
		else $error("shutdown did not force off");
	a_clear_hold_time: assert property ($fell(fault) |-> $past(clr_cnt) == CLEAR_LAST)
		else $error("latch cleared before hold time");
	a_clear_conditions: assert property ($fell(fault) |-> $past(cmd_s2) == 2'h0 && $past(sd_s2))
		else $error("latch cleared with command or shutdown active");
	a_dead_time_high: assert property ($rose(gate[0]) |-> $past(dcnt[1]) == DEAD_DONE)
		else $error("high side on before dead time");
	a_dead_time_low: assert property ($rose(gate[1]) |-> $past(dcnt[0]) == DEAD_DONE)
		else $error("low side on before dead time");
	a_trip_turns_off: assert property (trip[0] || trip[1] |=> gate == 2'h0 && fault)
		else $error("desat trip did not turn off");
	a_gate_follows_cmd: assert property (gate[0] |-> $past(cmd_s2[0]))
		else $error("high side on without command");
	a_timer_restart: assert property (cmd_s2 != 2'h0 |=> clr_cnt == '0)
		else $error("hold timer not restarted");

	// latch, flag, command and desat checks
	a_fault_restart: assert property (fault_cond |=> clr_cnt == '0)
		else $error("hold timer not restarted by fault");
	a_latch_holds_off: assert property (fault |=> gate == 2'h0)
		else $error("transistor on while fault latched");
	a_flag_low_drive: assert property (fault_flag_oe |-> !fault_flag_out)
		else $error("fault flag driven high");
	a_low_follows_cmd: assert property (gate[1] |-> $past(cmd_s2[1]))
		else $error("low side on without command");
	a_desat_only_on: assert property ((trip & ~gate) == 2'h0)
		else $error("desat trip while transistor off");
	a_both_cmd_block: assert property (cmd_s2 == 2'h3 |=> (gate & ~$past(gate)) == 2'h0)
		else $error("turn-on with both commands high");

	// main scenarios reached

	c_fault_cleared: cover property ($fell(fault));
	c_desat_trip: cover property (gate[0] ##1 trip[0]);
	c_complement_drive: cover property (gate[0] ##[1:60] gate[1]);
	c_shutdown_hit: cover property (gate[1] ##1 !sd_s2);
	c_both_cmd: cover property (cmd_s2 == 2'h3 && gate[1]);

endmodule

/* dv/gdfi_ctrl_model.sv */
// controller side model: command drive, shutdown drive, fault flag pull-up
`timescale 1ns/1ps
module gdfi_ctrl_model (
	input  wire logic hi_req,         // wanted high-side state
	input  wire logic lo_req,         // wanted low-side state
	input  wire logic comp_mode,      // low command is complement of high
	input  wire logic shut_req_n,     // wanted shutdown level
	input  wire logic fault_flag_out, // device pin drive level
	input  wire logic fault_flag_oe,  // device pulling pin low
	output logic      high_cmd,       // high-side command pin
	output logic      low_cmd,        // low-side command pin
	output logic      shutdown_in_n,  // shutdown pin
	output logic      fault_seen      // flag level read at controller
);
	// push-pull command drive, optional single signal with complement
	assign high_cmd = hi_req;
	assign low_cmd = comp_mode ? ~hi_req : lo_req;
	// tied high when unused, so shutdown reads inactive
	assign shutdown_in_n = shut_req_n;
	// pull-up: a released pin reads as fault
	assign fault_seen = fault_flag_oe ? fault_flag_out : 1'b1;
endmodule

/* dv/gdfi_top_tb_top.sv */
// testbench for the gate driver fault interlock block
`timescale 1ns/1ps
module gdfi_top_tb_top;
	import gdfi_pkg::*;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic       hi_req = 1'b0, lo_req = 1'b0, comp_mode = 1'b0, shut_req_n = 1'b1;
	logic       high_cmd, low_cmd, shutdown_in_n, fault_seen;
	logic [7:0] hs_sense = 8'h00, ls_sense = 8'h00;
	logic       high_gate_on, low_gate_on, fault_flag_out, fault_flag_oe;
	int         errors = 0, n_compared = 0, cycles = 0;

	// ---------------------------------------------------------------
	// clock, instances, timeout
	// ---------------------------------------------------------------
	always #50 clk = ~clk;
	gdfi_ctrl_model gdfi_ctrl_model_i (.hi_req(hi_req), .lo_req(lo_req),
		.comp_mode(comp_mode), .shut_req_n(shut_req_n), .fault_flag_out(fault_flag_out),
		.fault_flag_oe(fault_flag_oe), .high_cmd(high_cmd), .low_cmd(low_cmd),
		.shutdown_in_n(shutdown_in_n), .fault_seen(fault_seen));
	gdfi_top gdfi_top_i (.clk(clk), .arst_n(arst_n), .high_cmd(high_cmd), .low_cmd(low_cmd),
		.shutdown_in_n(shutdown_in_n), .high_side_desat_sense(hs_sense),
		.low_side_desat_sense(ls_sense), .high_gate_on(high_gate_on),
		.low_gate_on(low_gate_on), .fault_flag_out(fault_flag_out),
		.fault_flag_oe(fault_flag_oe));
	// cycle ceiling and shoot-through watch, sampled on the settled half
	always @(negedge clk)
	begin
		cycles++;
		chk(high_gate_on & low_gate_on, 1'b0, "both gates on");
		if (cycles == 5000)
		begin
			errors++;
			$display("[ERR] %0t cycle limit reached", $time);
			conclude();
		end
	end

	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic conclude();
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic seen, input logic exp, input string msg);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %0t %s: seen %b expected %b", $time, msg, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		chk(fault_seen, 1'b1, "flag after reset");
		step(90);
		chk(fault_seen, 1'b1, "flag before hold");
		step(2);
		chk(fault_seen, 1'b0, "flag after hold");
	endtask
	task automatic t_on_high();
		hi_req = 1'b1;
		step(2);
		chk(high_gate_on, 1'b0, "high early");
		step(2);
		chk(high_gate_on, 1'b1, "high on");
		chk(low_gate_on, 1'b0, "low stays off");
	endtask
	task automatic t_complement();
		comp_mode = 1'b1;
		hi_req = 1'b0;
		step(4);
		chk(high_gate_on, 1'b0, "high off");
		step(16);
		chk(low_gate_on, 1'b0, "low inside dead time");
		step(8);
		chk(low_gate_on, 1'b1, "low after dead time");
		hi_req = 1'b1;
		step(4);
		chk(high_gate_on, 1'b0, "high inside dead time");
		step(26);
		chk(high_gate_on, 1'b1, "high after dead time");
		comp_mode = 1'b0;
		hi_req = 1'b0;
	endtask
	task automatic t_ctrl_dead();
		step(30);
		lo_req = 1'b1;
		step(4);
		chk(low_gate_on, 1'b1, "no added dead time");
		hi_req = 1'b1;
		step(30);
		chk(high_gate_on, 1'b0, "both commands, high held off");
		chk(low_gate_on, 1'b1, "both commands, low stays on");
		hi_req = 1'b0;
		lo_req = 1'b0;
		step(30);
	endtask
	task automatic t_desat_below();
		hs_sense = THR_STEADY;
		hi_req = 1'b1;
		step(40);
		chk(high_gate_on, 1'b1, "sense at threshold stays on");
		chk(fault_seen, 1'b0, "no fault at threshold");
		hi_req = 1'b0;
		hs_sense = 8'h00;
		step(30);
	endtask
	task automatic t_shutdown();
		hi_req = 1'b1;
		step(4);
		chk(high_gate_on, 1'b1, "high before shutdown");
		shut_req_n = 1'b0;
		step(4);
		chk(high_gate_on, 1'b0, "shutdown forces off");
		chk(fault_seen, 1'b1, "shutdown flag");
		step(10);
		chk(high_gate_on, 1'b0, "command ignored");
		shut_req_n = 1'b1;
		step(100);
		chk(fault_seen, 1'b1, "command still high");
		hi_req = 1'b0;
		step(50);
		hi_req = 1'b1;
		step(3);
		hi_req = 1'b0;
		step(85);
		chk(fault_seen, 1'b1, "hold restarted");
		chk(high_gate_on, 1'b0, "pulse ignored");
		step(15);
		chk(fault_seen, 1'b0, "shutdown fault cleared");
	endtask
	task automatic t_desat(input logic ch, input logic [7:0] lvl);
		ls_sense = ch ? lvl : 8'h00;
		hs_sense = ch ? 8'h00 : lvl;
		lo_req = ch;
		hi_req = !ch;
		step(20);
		chk(ch ? low_gate_on : high_gate_on, 1'b1, "on during blanking");
		chk(fault_seen, 1'b0, "no trip in blanking");
		step(20);
		chk(ch ? low_gate_on : high_gate_on, 1'b0, "desat turns off");
		chk(fault_seen, 1'b1, "desat flag");
		hi_req = 1'b0;
		lo_req = 1'b0;
		hs_sense = 8'h00;
		ls_sense = 8'h00;
		step(100);
		chk(fault_seen, 1'b0, "desat fault cleared");
	endtask
	task automatic t_mid_reset();
		hi_req = 1'b1;
		step(4);
		chk(high_gate_on, 1'b1, "high on before reset");
		arst_n = 1'b0;
		step(1);
		chk(high_gate_on, 1'b0, "reset turns gate off");
		chk(fault_seen, 1'b1, "reset latches fault");
		hi_req = 1'b0;
		step(4);
		arst_n = 1'b1;
		step(90);
		chk(fault_seen, 1'b1, "flag before hold after reset");
		step(2);
		chk(fault_seen, 1'b0, "flag after hold after reset");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		step(5);
		arst_n = 1'b1;
		t_reset();
		t_on_high();
		t_complement();
		t_ctrl_dead();
		t_desat_below();
		t_shutdown();
		t_desat(1'b0, 8'hff);
		t_desat(1'b1, 8'h80);
		t_mid_reset();
		conclude();
	end
endmodule
